// file: inc/gpc_regs.svh
// Register offsets, field positions, reset values for the gigabit
// configuration, status and indirect access control registers.
// Assumes a 5-bit management register address and 16-bit data.
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

`define GPC_OFS_CONFIG        5'h09
`define GPC_OFS_STATUS        5'h0A
`define GPC_OFS_ACCESS_CTRL   5'h0D
`define GPC_OFS_ADDR_DATA     5'h0E

`define GPC_RST_CONFIG        16'h0300
`define GPC_RST_STATUS        16'h0000
`define GPC_RST_ACCESS_CTRL   16'h0000

`define GPC_CFG_TEST_HI       15
`define GPC_CFG_TEST_LO       13
`define GPC_CFG_MAN_EN        12
`define GPC_CFG_MAN_VAL       11
`define GPC_CFG_PORT_TYPE     10
`define GPC_CFG_ADV_FD        9
`define GPC_CFG_ADV_HD        8
`define GPC_CFG_REFLECT_AUTO  7
`define GPC_CFG_WMASK         16'hFF80

`define GPC_ST_FAULT          15
`define GPC_ST_MASTER         14
`define GPC_ST_LOC_OK         13
`define GPC_ST_REM_OK         12
`define GPC_ST_LP_FD          11
`define GPC_ST_LP_HD          10

`define GPC_AC_FUNC_HI        15
`define GPC_AC_FUNC_LO        14
`define GPC_AC_DEV_HI         4
`define GPC_AC_DEV_LO         0
`define GPC_AC_WMASK          16'hC01F

`endif

// file: inc/gpc_pkg.sv
// Types shared by the gigabit register slice.
// Assumes the offsets and fields come from gpc_regs.svh.
package gpc_pkg;

    // Indirect access function field encodings
    typedef enum logic [1:0] {
        GPC_FN_ADDRESS   = 2'h0,
        GPC_FN_DATA      = 2'h1,
        GPC_FN_DATA_INC  = 2'h2,
        GPC_FN_DATA_INCW = 2'h3
    } gpc_func_type;

    // Transmit test pattern selections
    typedef enum logic [2:0] {
        GPC_TM_NORMAL     = 3'h0,
        GPC_TM_WAVEFORM   = 3'h1,
        GPC_TM_JIT_MASTER = 3'h2,
        GPC_TM_JIT_SLAVE  = 3'h3,
        GPC_TM_DISTORTION = 3'h4,
        GPC_TM_MLT3_IDLE  = 3'h5,
        GPC_TM_REP_0001   = 3'h6,
        GPC_TM_PULSE_63   = 3'h7
    } gpc_test_type;

endpackage

// file: rtl/gpc_sync3.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the input is asynchronous to i_sys_clk.
`timescale 1ns/10ps
module gpc_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;

    // Accept a change once stages two and three agree
    assign out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));

    // Shift chain
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            out_reg <= '0;
        end else begin
            s1_reg  <= i_async;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign o_sync = out_reg;
endmodule // gpc_sync3

// file: rtl/gpc_pattern_gen.sv
// Transmit conformance test symbol generator.
// Assumes one symbol per clock, sel held stable by the register file.
`timescale 1ns/10ps
module gpc_pattern_gen (
    input  wire logic                i_sys_clk,
    input  wire logic                i_rstn,
    input  wire gpc_pkg::gpc_test_type i_sel,
    output logic                     o_active,
    output logic                     o_sym
);
    logic [5:0]  cnt_reg;
    logic [10:0] lfsr_reg;
    logic        sym_next;
    logic [5:0]  cnt_next;
    logic [10:0] lfsr_next;
    logic        act_reg;
    logic        sym_reg;

    // Counter and scrambler advance every cycle
    assign cnt_next  = cnt_reg + 6'h01;
    assign lfsr_next = {lfsr_reg[9:0], lfsr_reg[10] ^ lfsr_reg[8]};

    // Symbol selection per test
    always_comb begin
        case (i_sel)
            gpc_pkg::GPC_TM_NORMAL:     sym_next = 1'b0;
            gpc_pkg::GPC_TM_MLT3_IDLE:  sym_next = lfsr_reg[10];
            gpc_pkg::GPC_TM_REP_0001:   sym_next = (cnt_reg[1:0] == 2'h3);
            gpc_pkg::GPC_TM_PULSE_63:   sym_next = (cnt_reg == 6'h00);
            gpc_pkg::GPC_TM_WAVEFORM:   sym_next = cnt_reg[0];
            gpc_pkg::GPC_TM_JIT_MASTER: sym_next = cnt_reg[1];
            gpc_pkg::GPC_TM_JIT_SLAVE:  sym_next = cnt_reg[2];
            gpc_pkg::GPC_TM_DISTORTION: sym_next = lfsr_reg[0] ^ cnt_reg[3];
            default:                    sym_next = 1'b0;
        endcase
    end

    // Pattern state
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg  <= 6'h00;
            lfsr_reg <= 11'h7FF;
            act_reg  <= 1'b0;
            sym_reg  <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            lfsr_reg <= lfsr_next;
            act_reg  <= (i_sel != gpc_pkg::GPC_TM_NORMAL);
            sym_reg  <= sym_next;
        end
    end

    assign o_active = act_reg;
    assign o_sym    = sym_reg;
endmodule // gpc_pattern_gen

// file: rtl/gpc_reg_slice.sv
// Gigabit configuration/status and indirect access control registers.
// Assumes an MDIO frame decoder presents one-cycle read/write strobes
// on i_sys_clk; PHY status inputs are asynchronous pins.
//
// Behaviour
// - Test field 0 normal, 1-7 test patterns
// - Modes 5,6,7: idles, 0001, pulse+63 zeros
// - Bit 12 enables manual role selection
// - Bit 11 forces master (1) or slave
// - Bit 10 reports multi-port or single-port
// - Bits 9,8 advertise gigabit duplex, strap reset
// - Bit 7 runs reflectometry after link down
// - Status bit 15 latches fault, read clears
// - Status bit 14 shows resolved master role
// - Bits 13,12 show local/remote receiver ok
// - Bits 11,10 show partner gigabit abilities
// - Bits 7-0 read-only idle error count
// - Function 00 address, 01 data no increment
// - Function 10 inc always, 11 inc writes
// - Bits 4:0 select target MMD
// - Port maps address when 00, else data
`timescale 1ns/10ps
`include "gpc_regs.svh"
module gpc_reg_slice (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    // Management register access
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [4:0]  i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    output logic             o_reg_rvalid,
    // Straps, caught after reset release
    input  wire logic        i_strap_adv_fd,
    input  wire logic        i_strap_adv_hd,
    // PHY status pins
    input  wire logic        i_role_fault,
    input  wire logic        i_role_master,
    input  wire logic        i_local_rx_ok,
    input  wire logic        i_remote_rx_ok,
    input  wire logic        i_partner_fd,
    input  wire logic        i_partner_hd,
    input  wire logic        i_link_up,
    input  wire logic [7:0]  i_idle_err_count,
    // Control outputs toward the PHY core
    output logic             o_manual_role_enable,
    output logic             o_manual_role_value,
    output logic             o_port_multi,
    output logic             o_adv_gig_full_duplex,
    output logic             o_adv_gig_half_duplex,
    output logic             o_cable_reflect_start,
    output logic             o_test_active,
    output logic             o_test_sym,
    // Indirect MMD access
    output logic             o_mmd_wr,
    output logic             o_mmd_rd,
    output logic [4:0]       o_mmd_target_select,
    output logic [15:0]      o_mmd_addr,
    output logic [15:0]      o_mmd_wdata,
    input  wire logic [15:0] i_mmd_rdata
);
    localparam int PIN_W = 7;

    logic [15:0] config_reg;
    logic [15:0] access_reg;
    logic [15:0] mmd_addr_reg;
    logic        fault_reg;
    logic        strap_done_reg;
    logic        link_prev_reg;
    logic [15:0] rdata_reg;
    logic        rvalid_reg;
    logic        reflect_reg;
    logic        mmd_wr_reg;
    logic        mmd_rd_reg;
    logic [15:0] mmd_wdata_reg;
    logic [15:0] mmd_addr_next;
    logic        fault_next;
    logic [15:0] rdata_next;
    logic [PIN_W-1:0] pins_sync;
    logic [7:0]  idle_cnt_sync;
    logic        idle_cnt_hold;
    logic [7:0]  idle_cnt_reg;

    // Address decode
    wire sel_cfg  = (i_reg_addr == `GPC_OFS_CONFIG);
    wire sel_st   = (i_reg_addr == `GPC_OFS_STATUS);
    wire sel_ac   = (i_reg_addr == `GPC_OFS_ACCESS_CTRL);
    wire sel_port = (i_reg_addr == `GPC_OFS_ADDR_DATA);
    wire [1:0] func = access_reg[`GPC_AC_FUNC_HI:`GPC_AC_FUNC_LO];
    wire fn_addr = (func == gpc_pkg::GPC_FN_ADDRESS);
    wire port_wr = i_reg_wr & sel_port;
    wire port_rd = i_reg_rd & sel_port;
    // Post increment selection
    wire inc_rd  = (func == gpc_pkg::GPC_FN_DATA_INC);
    wire inc_wr  = inc_rd | (func == gpc_pkg::GPC_FN_DATA_INCW);

    // Synchronised status pins
    wire role_fault_s = pins_sync[0];
    wire master_s     = pins_sync[1];
    wire loc_ok_s     = pins_sync[2];
    wire rem_ok_s     = pins_sync[3];
    wire lp_fd_s      = pins_sync[4];
    wire lp_hd_s      = pins_sync[5];
    wire link_up_s    = pins_sync[6];

    gpc_sync3 #(.WIDTH(PIN_W)) u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_async   ({i_link_up, i_partner_hd, i_partner_fd, i_remote_rx_ok,
                     i_local_rx_ok, i_role_master, i_role_fault}),
        .o_sync    (pins_sync)
    );

    gpc_sync3 #(.WIDTH(8)) u_cnt_sync (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_async   (i_idle_err_count),
        .o_sync    (idle_cnt_sync)
    );

    // Status word assembly, reserved bits zero
    wire [15:0] status_word = {fault_reg,
                               master_s,
                               loc_ok_s,
                               rem_ok_s,
                               lp_fd_s,
                               lp_hd_s,
                               2'h0,
                               idle_cnt_reg};

    // Read data multiplexer; unmapped offsets read zero
    assign rdata_next = sel_cfg  ? config_reg :
                        sel_st   ? status_word :
                        sel_ac   ? access_reg :
                        sel_port ? (fn_addr ? mmd_addr_reg
                                            : i_mmd_rdata) :
                        16'h0000;

    // Fault latch: set wins over read clear, re-set if still present
    assign fault_next = role_fault_s |
                        (fault_reg & ~(i_reg_rd & sel_st));

    // MMD address register update with post increment
    always_comb begin
        mmd_addr_next = mmd_addr_reg;
        if (port_wr && fn_addr) begin
            mmd_addr_next = i_reg_wdata;
        end else if ((port_wr && inc_wr) || (port_rd && inc_rd)) begin
            mmd_addr_next = mmd_addr_reg + 16'h0001;
        end
    end

    // Configuration register, writable fields only
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            config_reg     <= `GPC_RST_CONFIG;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            config_reg[`GPC_CFG_ADV_FD] <= i_strap_adv_fd;
            config_reg[`GPC_CFG_ADV_HD] <= i_strap_adv_hd;
        end else if (i_reg_wr && sel_cfg) begin
            config_reg <= i_reg_wdata & `GPC_CFG_WMASK;
        end
    end

    // Indirect access control register
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            access_reg <= `GPC_RST_ACCESS_CTRL;
        end else if (i_reg_wr && sel_ac) begin
            access_reg <= i_reg_wdata & `GPC_AC_WMASK;
        end
    end

    // Status latch and idle count sample
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fault_reg    <= 1'b0;
            idle_cnt_reg <= 8'h00;
        end else begin
            fault_reg    <= fault_next;
            idle_cnt_reg <= idle_cnt_hold ? idle_cnt_reg : idle_cnt_sync;
        end
    end

    // Freeze the count while a status read is under way
    assign idle_cnt_hold = i_reg_rd & sel_st;

    // Read response
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_reg  <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= i_reg_rd ? rdata_next : rdata_reg;
            rvalid_reg <= i_reg_rd;
        end
    end

    // MMD pointer and forwarded data accesses
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mmd_addr_reg  <= 16'h0000;
            mmd_wr_reg    <= 1'b0;
            mmd_rd_reg    <= 1'b0;
            mmd_wdata_reg <= 16'h0000;
        end else begin
            mmd_addr_reg  <= mmd_addr_next;
            mmd_wr_reg    <= port_wr & ~fn_addr;
            mmd_rd_reg    <= port_rd & ~fn_addr;
            mmd_wdata_reg <= port_wr ? i_reg_wdata : mmd_wdata_reg;
        end
    end

    // Reflectometry start on link-down edge when enabled
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            link_prev_reg <= 1'b0;
            reflect_reg   <= 1'b0;
        end else begin
            link_prev_reg <= link_up_s;
            reflect_reg   <= config_reg[`GPC_CFG_REFLECT_AUTO] &
                             link_prev_reg & ~link_up_s;
        end
    end

    gpc_pattern_gen u_pattern (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_sel     (gpc_pkg::gpc_test_type'(
                        config_reg[`GPC_CFG_TEST_HI:`GPC_CFG_TEST_LO])),
        .o_active  (o_test_active),
        .o_sym     (o_test_sym)
    );

    // Register-driven outputs
    assign o_reg_rdata           = rdata_reg;
    assign o_reg_rvalid          = rvalid_reg;
    assign o_manual_role_enable  = config_reg[`GPC_CFG_MAN_EN];
    assign o_manual_role_value   = config_reg[`GPC_CFG_MAN_VAL];
    assign o_port_multi          = config_reg[`GPC_CFG_PORT_TYPE];
    assign o_adv_gig_full_duplex = config_reg[`GPC_CFG_ADV_FD];
    assign o_adv_gig_half_duplex = config_reg[`GPC_CFG_ADV_HD];
    assign o_cable_reflect_start = reflect_reg;
    assign o_mmd_wr              = mmd_wr_reg;
    assign o_mmd_rd              = mmd_rd_reg;
    assign o_mmd_target_select   =
        access_reg[`GPC_AC_DEV_HI:`GPC_AC_DEV_LO];
    assign o_mmd_addr            = mmd_addr_reg;
    assign o_mmd_wdata           = mmd_wdata_reg;
endmodule // gpc_reg_slice

// file: test/gpc_reg_slice_assertions.sv
// Port checks for the gigabit register slice.
// Assumes one-cycle strobes and at least one idle cycle between reads.
`timescale 1ns/10ps
`include "gpc_regs.svh"
module gpc_reg_slice_checker (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [4:0]  i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    input  wire logic [15:0] o_reg_rdata,
    input  wire logic        o_reg_rvalid,
    input  wire logic        o_manual_role_enable,
    input  wire logic        o_manual_role_value,
    input  wire logic        o_port_multi,
    input  wire logic        o_adv_gig_full_duplex,
    input  wire logic        o_adv_gig_half_duplex,
    input  wire logic        o_cable_reflect_start,
    input  wire logic        o_test_active,
    input  wire logic        o_mmd_wr,
    input  wire logic        o_mmd_rd,
    input  wire logic [4:0]  o_mmd_target_select,
    input  wire logic [15:0] o_mmd_addr,
    input  wire logic [15:0] o_mmd_wdata,
    input  wire logic [15:0] i_mmd_rdata
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    logic [1:0]  fn_q;
    logic [2:0]  tm_q;
    logic        auto_q;
    logic [4:0]  ra_q;
    logic [15:0] rmask;
    wire w_cfg  = i_reg_wr && i_reg_addr == `GPC_OFS_CONFIG;
    wire w_acc  = i_reg_wr && i_reg_addr == `GPC_OFS_ACCESS_CTRL;
    wire w_port = i_reg_wr && i_reg_addr == `GPC_OFS_ADDR_DATA;
    wire r_port = i_reg_rd && i_reg_addr == `GPC_OFS_ADDR_DATA;
    // Bits that must read zero for the offset last read
    assign rmask = (ra_q == `GPC_OFS_CONFIG) ? 16'h007F :
                   (ra_q == `GPC_OFS_STATUS) ? 16'h0300 :
                   (ra_q == `GPC_OFS_ACCESS_CTRL) ? 16'h3FE0 :
                   (ra_q == `GPC_OFS_ADDR_DATA) ? 16'h0000 : 16'hFFFF;
    // Shadows of written fields and of the read offset
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fn_q   <= 2'h0;
            tm_q   <= 3'h0;
            auto_q <= 1'b0;
            ra_q   <= 5'h00;
        end else begin
            if (w_acc) fn_q <= i_reg_wdata[15:14];
            if (w_cfg) tm_q <= i_reg_wdata[15:13];
            if (w_cfg) auto_q <= i_reg_wdata[7];
            if (i_reg_rd) ra_q <= i_reg_addr;
        end
    end
    a_cfg_fields_apply: assert property (w_cfg |=>
        {o_manual_role_enable, o_manual_role_value, o_port_multi,
         o_adv_gig_full_duplex, o_adv_gig_half_duplex}
        == $past(i_reg_wdata[12:8])) else $error("config outputs wrong");
    a_test_mode_active: assert property (w_cfg |-> ##2
        o_test_active == (tm_q != 3'h0)) else $error("test active wrong");
    a_reflect_needs_en: assert property (
        o_cable_reflect_start |-> auto_q) else $error("reflect not enabled");
    a_reflect_one_pulse: assert property (
        o_cable_reflect_start |=> !o_cable_reflect_start)
        else $error("reflect pulse too long");
    a_target_follows: assert property (w_acc |=>
        o_mmd_target_select == $past(i_reg_wdata[4:0]))
        else $error("target select wrong");
    a_port_addr_load: assert property (w_port && fn_q == 2'h0 |=>
        o_mmd_addr == $past(i_reg_wdata) && !o_mmd_wr)
        else $error("address load wrong");
    a_port_data_write: assert property (w_port && fn_q != 2'h0 |=>
        o_mmd_wr && o_mmd_wdata == $past(i_reg_wdata))
        else $error("data write wrong");
    a_write_post_inc: assert property (w_port && fn_q[1] |=>
        o_mmd_addr == $past(o_mmd_addr) + 16'h0001)
        else $error("write increment wrong");
    a_plain_no_inc: assert property (
        (w_port || r_port) && fn_q == 2'h1 |=> $stable(o_mmd_addr))
        else $error("plain data moved address");
    a_read_post_inc: assert property (r_port && fn_q == 2'h2 |=>
        o_mmd_addr == $past(o_mmd_addr) + 16'h0001)
        else $error("read increment wrong");
    a_read_no_inc: assert property (r_port && fn_q == 2'h3 |=>
        $stable(o_mmd_addr)) else $error("read moved address");
    a_port_read_data: assert property (r_port && fn_q != 2'h0 |=>
        o_mmd_rd && o_reg_rdata == $past(i_mmd_rdata))
        else $error("port read data wrong");
    a_reserved_zero: assert property (o_reg_rvalid |->
        (o_reg_rdata & rmask) == 16'h0000) else $error("reserved bits set");
endmodule // gpc_reg_slice_checker

// file: test/gpc_host_model.sv
// Management host model issuing register strobes to the slice.
// Assumes strobes are launched and released on falling clock edges.
`timescale 1ns/10ps
module gpc_host_model (
    input  wire logic        i_sys_clk,
    input  wire logic [15:0] i_reg_rdata,
    input  wire logic        i_reg_rvalid,
    output logic             o_reg_wr,
    output logic             o_reg_rd,
    output logic [4:0]       o_reg_addr,
    output logic [15:0]      o_reg_wdata
);
    // Idle bus at time zero
    initial begin
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_addr  = 5'h00;
        o_reg_wdata = 16'h0000;
    end
    // One-cycle write; released lines show inverted values
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge i_sys_clk);
        o_reg_addr  = a;
        o_reg_wdata = d;
        o_reg_wr    = 1'b1;
        @(negedge i_sys_clk);
        o_reg_wr    = 1'b0;
        o_reg_addr  = ~a;
        o_reg_wdata = ~d;
    endtask
    // One-cycle read; data taken with the valid pulse, bounded wait
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        d = 16'hXXXX;
        @(negedge i_sys_clk);
        o_reg_addr = a;
        o_reg_rd   = 1'b1;
        @(negedge i_sys_clk);
        o_reg_rd   = 1'b0;
        o_reg_addr = ~a;
        for (int i = 0; i < 3; i++) begin
            if (i_reg_rvalid === 1'b1) begin
                d = i_reg_rdata;
                break;
            end
            @(negedge i_sys_clk);
        end
    endtask
endmodule // gpc_host_model

// file: test/gpc_reg_slice_test.sv
// Self-checking bench for the gigabit register slice.
// Assumes the host model drives the register strobes.
`timescale 1ns/10ps
`include "gpc_regs.svh"
module gpc_reg_slice_test;
    logic i_sys_clk, i_rstn, i_reg_wr, i_reg_rd, o_reg_rvalid;
    logic i_strap_adv_fd, i_strap_adv_hd, i_role_fault, i_role_master;
    logic i_local_rx_ok, i_remote_rx_ok, i_partner_fd, i_partner_hd;
    logic i_link_up, o_manual_role_enable, o_manual_role_value;
    logic o_port_multi, o_adv_gig_full_duplex, o_adv_gig_half_duplex;
    logic o_cable_reflect_start, o_test_active, o_test_sym;
    logic o_mmd_wr, o_mmd_rd;
    logic [4:0]  i_reg_addr, o_mmd_target_select;
    logic [7:0]  i_idle_err_count;
    logic [15:0] i_reg_wdata, o_reg_rdata, o_mmd_addr, o_mmd_wdata;
    logic [15:0] i_mmd_rdata;
    int          n_errors = 0;
    int          n_checks = 0;
    // Extended register content seen through the port
    assign i_mmd_rdata = o_mmd_addr ^ 16'hA5A5;
    gpc_reg_slice dut (.*);
    gpc_host_model host (.i_sys_clk(i_sys_clk), .i_reg_rdata(o_reg_rdata),
        .i_reg_rvalid(o_reg_rvalid), .o_reg_wr(i_reg_wr),
        .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr),
        .o_reg_wdata(i_reg_wdata));
    // Clock source
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    task automatic give_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    // Counts high cycles of the symbol or the reflect pulse
    task automatic cnt(input logic s, input int n, input logic [15:0] e);
        int   k;
        logic v;
        k = 0;
        repeat (n) begin
            @(negedge i_sys_clk);
            v = s ? o_cable_reflect_start : o_test_sym;
            // An unknown sample spoils the count on purpose
            k += (v === 1'b1) ? 32'h1 : (v === 1'b0) ? 32'h0 : 32'h1000;
        end
        chk(16'(k), e);
    endtask
    wire [15:0] ctl = {11'h000, o_manual_role_enable, o_manual_role_value,
        o_port_multi, o_adv_gig_full_duplex, o_adv_gig_half_duplex};
    // Main sequence
    initial begin
        {i_rstn, i_strap_adv_hd, i_role_fault, i_role_master} = 4'h0;
        {i_local_rx_ok, i_remote_rx_ok, i_partner_fd, i_partner_hd} = 4'h0;
        {i_strap_adv_fd, i_link_up} = 2'h3;
        i_idle_err_count = 8'h00;
        cyc(4);
        chk(ctl, 16'h0003);
        i_rstn = 1'b1;
        cyc(2);
        rdc(`GPC_OFS_CONFIG, 16'h0200);
        rdc(`GPC_OFS_STATUS, 16'h0000);
        rdc(`GPC_OFS_ACCESS_CTRL, 16'h0000);
        rdc(5'h05, 16'h0000);
        host.wr(`GPC_OFS_CONFIG, 16'hFFFF);
        chk(ctl, 16'h001F);
        rdc(`GPC_OFS_CONFIG, 16'hFF80);
        host.wr(`GPC_OFS_CONFIG, 16'h1400);
        chk(ctl, 16'h0014);
        for (int m = 1; m < 8; m++) begin
            host.wr(`GPC_OFS_CONFIG, {m[2:0], 13'h0000});
            cyc(1);
            chk({15'h0000, o_test_active}, 16'h0001);
        end
        cnt(1'b0, 128, 16'h0002);
        host.wr(`GPC_OFS_CONFIG, 16'hC000);
        cnt(1'b0, 64, 16'h0010);
        host.wr(`GPC_OFS_CONFIG, 16'hA000);
        // One full scrambler period holds 1024 ones
        cnt(1'b0, 2047, 16'h0400);
        host.wr(`GPC_OFS_CONFIG, 16'h0000);
        cyc(1);
        chk({15'h0000, o_test_active}, 16'h0000);
        cnt(1'b0, 64, 16'h0000);
        {i_role_master, i_local_rx_ok, i_partner_fd} = 3'h7;
        i_idle_err_count = 8'h5A;
        cyc(8);
        rdc(`GPC_OFS_STATUS, 16'h685A);
        host.wr(`GPC_OFS_STATUS, 16'hFFFF);
        rdc(`GPC_OFS_STATUS, 16'h685A);
        i_role_fault = 1'b1;
        cyc(8);
        i_role_fault = 1'b0;
        cyc(8);
        rdc(`GPC_OFS_STATUS, 16'hE85A);
        rdc(`GPC_OFS_STATUS, 16'h685A);
        i_role_fault = 1'b1;
        cyc(8);
        rdc(`GPC_OFS_STATUS, 16'hE85A);
        i_role_fault = 1'b0;
        {i_role_master, i_local_rx_ok, i_partner_fd} = 3'h0;
        {i_remote_rx_ok, i_partner_hd} = 2'h3;
        i_idle_err_count = 8'hA5;
        cyc(8);
        rdc(`GPC_OFS_STATUS, 16'h94A5);
        rdc(`GPC_OFS_STATUS, 16'h14A5);
        host.wr(`GPC_OFS_CONFIG, 16'h0080);
        i_link_up = 1'b0;
        cnt(1'b1, 16, 16'h0001);
        i_link_up = 1'b1;
        cyc(8);
        host.wr(`GPC_OFS_CONFIG, 16'h0000);
        i_link_up = 1'b0;
        cnt(1'b1, 16, 16'h0000);
        host.wr(`GPC_OFS_ACCESS_CTRL, 16'hFFFF);
        rdc(`GPC_OFS_ACCESS_CTRL, 16'hC01F);
        host.wr(`GPC_OFS_ACCESS_CTRL, 16'h001F);
        chk({11'h000, o_mmd_target_select}, 16'h001F);
        host.wr(`GPC_OFS_ADDR_DATA, 16'h0100);
        chk(o_mmd_addr, 16'h0100);
        rdc(`GPC_OFS_ADDR_DATA, 16'h0100);
        host.wr(`GPC_OFS_ACCESS_CTRL, 16'h401F);
        host.wr(`GPC_OFS_ADDR_DATA, 16'h1234);
        chk(o_mmd_wdata, 16'h1234);
        rdc(`GPC_OFS_ADDR_DATA, 16'hA4A5);
        host.wr(`GPC_OFS_ACCESS_CTRL, 16'h801F);
        host.wr(`GPC_OFS_ADDR_DATA, 16'h0001);
        chk(o_mmd_addr, 16'h0101);
        rdc(`GPC_OFS_ADDR_DATA, 16'hA4A4);
        chk(o_mmd_addr, 16'h0102);
        host.wr(`GPC_OFS_ACCESS_CTRL, 16'hC01F);
        host.wr(`GPC_OFS_ADDR_DATA, 16'h0002);
        rdc(`GPC_OFS_ADDR_DATA, 16'hA4A6);
        chk(o_mmd_addr, 16'h0103);
        give_verdict();
    end
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
endmodule // gpc_reg_slice_test

bind gpc_reg_slice gpc_reg_slice_checker chk_i (.*);
